// ### src/tshr_params.svh
// constants shared by the temperature readout design
`ifndef TSHR_PARAMS_SVH
`define TSHR_PARAMS_SVH
`define TSHR_CMD_WR_CFG 8'h0c
`define TSHR_CMD_RD_CFG 8'hac
`define TSHR_CMD_START 8'hee
`define TSHR_CMD_RD_TEMP 8'haa
`define TSHR_CMD_RD_CNT 8'ha0
`define TSHR_CMD_LD_SLOPE 8'h41
`define TSHR_CFG_DONE 7
`define TSHR_CFG_HOST 1
`define TSHR_CFG_SINGLE 0
`define TSHR_CFG_RST 8'h00
`define TSHR_CFG_WR_MASK 8'h03
`define TSHR_TEMP_PRESET 9'h192
`define TSHR_COUNT_BASE 9'h0c8
`define TSHR_SLOPE_BASE 9'h040
`define TSHR_SLOPE_STEP 9'h001
`define TSHR_GATE_TICKS 16'h0100
`define TSHR_CMD_LAST 5'h07
`define TSHR_WR_LAST 5'h0f
`define TSHR_BIT_SAT 5'h1f
`endif

// ### src/tshr_pkg.sv
// types shared by the temperature readout design
package tshr_pkg;
    typedef struct packed {
        logic [7:0] cfg;
        logic [8:0] temp;
        logic [8:0] cnt;
    } tshr_snap_t;
    typedef struct packed {
        logic [7:0] op;
        logic [7:0] data;
    } tshr_cmd_t;
    typedef enum logic [1:0] {
        tshr_st_idle = 2'b01,
        tshr_st_conv = 2'b10
    } tshr_state_t;
endpackage

// ### src/tshr_meas.sv
// gated down-counter, temperature register and slope accumulator
`include "tshr_params.svh"
module tshr_meas
    import tshr_pkg::*;
#(
    parameter logic [8:0] COUNT_BASE = `TSHR_COUNT_BASE,
    parameter logic [8:0] SLOPE_BASE = `TSHR_SLOPE_BASE,
    parameter logic [8:0] SLOPE_STEP = `TSHR_SLOPE_STEP,
    parameter logic [8:0] TEMP_PRESET = `TSHR_TEMP_PRESET,
    parameter logic [15:0] GATE_TICKS = `TSHR_GATE_TICKS
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic start,
    input wire logic low_tick,
    input wire logic high_tick,
    input wire logic load_slope,
    output logic [8:0] cnt,
    output logic [8:0] temp,
    output logic gate,
    output logic done
);
    logic [8:0] cnt_ff, temp_ff, slope_ff;
    logic [15:0] gate_cnt_ff;
    logic gate_ff, done_ff;
    wire step = gate_ff & low_tick & (cnt_ff == 9'h000);
    wire dec = gate_ff & low_tick & (cnt_ff != 9'h000);
    wire gate_end = gate_ff & high_tick & (gate_cnt_ff == GATE_TICKS - 16'h0001);
    wire [8:0] nxt_cnt = start ? COUNT_BASE : (load_slope | step) ? slope_ff :
        dec ? cnt_ff - 9'h001 : cnt_ff;
    wire [8:0] nxt_temp = start ? TEMP_PRESET : step ? temp_ff + 9'h001 : temp_ff;
    wire [8:0] nxt_slope = start ? SLOPE_BASE : step ? slope_ff + SLOPE_STEP : slope_ff;
    wire [15:0] nxt_gate_cnt = start ? 16'h0000 :
        (gate_ff & high_tick) ? gate_cnt_ff + 16'h0001 : gate_cnt_ff;
    wire nxt_gate = start | (gate_ff & ~gate_end);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cnt_ff <= 9'h000;
            temp_ff <= 9'h000;
            slope_ff <= 9'h000;
            gate_cnt_ff <= 16'h0000;
            gate_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            temp_ff <= nxt_temp;
            slope_ff <= nxt_slope;
            gate_cnt_ff <= nxt_gate_cnt;
            gate_ff <= nxt_gate;
            done_ff <= gate_end;
        end
    end
    assign cnt = cnt_ff;
    assign temp = temp_ff;
    assign gate = gate_ff;
    assign done = done_ff;

    a_preset_start: assert property (
        @(posedge mclk) disable iff (!nrst)
        start |=> (cnt_ff == COUNT_BASE) && (temp_ff == TEMP_PRESET) && gate_ff)
        else $error("counter or temperature not preset at start");
    a_count_in_gate: assert property (
        @(posedge mclk) disable iff (!nrst)
        (dec && !start && !load_slope) |=> cnt_ff == $past(cnt_ff) - 9'h001)
        else $error("counter did not count down inside the gate");
    a_step_on_zero: assert property (
        @(posedge mclk) disable iff (!nrst)
        (gate_ff && low_tick && cnt_ff == 9'h000 && !start) |=> temp_ff == $past(temp_ff) + 9'h001)
        else $error("temperature not stepped on counter empty");
    a_reload_slope: assert property (
        @(posedge mclk) disable iff (!nrst)
        (step && !start) |=> cnt_ff == $past(slope_ff))
        else $error("counter not reloaded from slope accumulator");
    a_freeze_closed: assert property (
        @(posedge mclk) disable iff (!nrst)
        (!gate_ff && !start && !load_slope) |=> $stable(cnt_ff) && $stable(temp_ff))
        else $error("counter moved with the gate closed");
    a_load_slope_cmd: assert property (
        @(posedge mclk) disable iff (!nrst)
        (load_slope && !start) |=> cnt_ff == $past(slope_ff))
        else $error("load slope did not copy accumulator");
endmodule

// ### src/tshr_link.sv
// serial command port on the link clock
`include "tshr_params.svh"
module tshr_link
    import tshr_pkg::*;
(
    input wire logic sclk,
    input wire logic nrst,
    input wire logic sel,
    input wire logic dq_in,
    output logic dq_out,
    output logic dq_oe_n,
    input wire logic snap_req_tgl,
    input wire tshr_snap_t snap,
    output logic snap_ack_tgl,
    output tshr_cmd_t cmd,
    output logic cmd_tgl
);
    function automatic logic is_read(input logic [7:0] op);
        is_read = (op == `TSHR_CMD_RD_CFG) || (op == `TSHR_CMD_RD_TEMP) ||
            (op == `TSHR_CMD_RD_CNT);
    endfunction
    function automatic logic [8:0] rd_word(input logic [7:0] op, input tshr_snap_t s);
        rd_word = (op == `TSHR_CMD_RD_CFG) ? {1'b0, s.cfg} :
            (op == `TSHR_CMD_RD_TEMP) ? s.temp :
            (op == `TSHR_CMD_RD_CNT) ? s.cnt : 9'h000;
    endfunction

    logic [4:0] bit_cnt_ff;
    logic [15:0] rx_ff;
    logic [8:0] tx_ff;
    logic rd_act_ff, req_s1_ff, req_s2_ff, ack_ff, cmd_tgl_ff, dq_out_ff, dq_oe_n_ff;
    tshr_snap_t snap_ff;
    tshr_cmd_t cmd_ff;
    // deselect ends the frame even though sclk may have stopped
    wire frame_rst_n = nrst & sel;
    wire [15:0] nxt_rx = {dq_in, rx_ff[15:1]};
    wire cmd_done = bit_cnt_ff == `TSHR_CMD_LAST;
    wire wr_done = (bit_cnt_ff == `TSHR_WR_LAST) && (nxt_rx[7:0] == `TSHR_CMD_WR_CFG);
    wire ev = (cmd_done && nxt_rx[15:8] != `TSHR_CMD_WR_CFG) || wr_done;
    wire [4:0] nxt_bit_cnt = (bit_cnt_ff == `TSHR_BIT_SAT) ? bit_cnt_ff : bit_cnt_ff + 5'h01;
    wire [8:0] nxt_tx = cmd_done ? rd_word(nxt_rx[15:8], snap_ff) : tx_ff >> 1;
    wire nxt_rd_act = cmd_done ? is_read(nxt_rx[15:8]) : rd_act_ff;
    wire tshr_cmd_t nxt_cmd = wr_done ? tshr_cmd_t'{op: nxt_rx[7:0], data: nxt_rx[15:8]} :
        tshr_cmd_t'{op: nxt_rx[15:8], data: 8'h00};

    always_ff @(posedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            bit_cnt_ff <= 5'h00;
            rx_ff <= 16'h0000;
            tx_ff <= 9'h000;
            rd_act_ff <= 1'b0;
        end else begin
            bit_cnt_ff <= nxt_bit_cnt;
            rx_ff <= nxt_rx;
            tx_ff <= nxt_tx;
            rd_act_ff <= nxt_rd_act;
        end
    end

    // the snapshot word is held until the far side has seen the toggle; the command word changes on each command event with no acknowledge
    always_ff @(posedge sclk or negedge nrst) begin
        if (!nrst) begin
            req_s1_ff <= 1'b0;
            req_s2_ff <= 1'b0;
            ack_ff <= 1'b0;
            snap_ff <= '0;
            cmd_ff <= '0;
            cmd_tgl_ff <= 1'b0;
        end else begin
            req_s1_ff <= snap_req_tgl;
            req_s2_ff <= req_s1_ff;
            if (req_s2_ff != ack_ff) begin
                snap_ff <= snap;
                ack_ff <= req_s2_ff;
            end
            if (ev) begin
                cmd_ff <= nxt_cmd;
                cmd_tgl_ff <= ~cmd_tgl_ff;
            end
        end
    end

    // read data changes on the falling edge so the host samples it on the rising one
    always_ff @(negedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            dq_out_ff <= 1'b0;
            dq_oe_n_ff <= 1'b1;
        end else begin
            dq_out_ff <= tx_ff[0];
            dq_oe_n_ff <= ~rd_act_ff;
        end
    end
    assign dq_out = dq_out_ff;
    assign dq_oe_n = dq_oe_n_ff;
    assign snap_ack_tgl = ack_ff;
    assign cmd = cmd_ff;
    assign cmd_tgl = cmd_tgl_ff;

    a_read_load: assert property (
        @(posedge sclk) disable iff (!frame_rst_n)
        (cmd_done && nxt_rx[15:8] == `TSHR_CMD_RD_CNT) |=> rd_act_ff && tx_ff == $past(snap_ff.cnt))
        else $error("counter read not loaded after command byte");
endmodule

// ### src/tshr_readout.sv
// temperature readout top: oscillator sampling, conversion control, config and link
//
// Summary of operation
// - temperature is a 9-bit value with a half degree least significant bit.
// - the down-counter counts low-tempco oscillator edges only while the high-tempco gate is open.
// - conversion start presets the counter and the temperature register to minus 55 degrees.
// - each time the counter is empty on a count edge inside the gate the temperature steps by one.
// - on that event the counter reloads from the slope accumulator and keeps counting.
// - in single conversion mode, when the gate closes the counter freezes and its residue stays readable.
// - command 0xee starts one conversion, issued after single conversion mode is set.
// - command 0xac returns the configuration byte whose top bit is set once a conversion ends.
// - command 0xa0 returns the 9-bit counter contents like the temperature read.
// - command 0x41 has no data and copies the slope accumulator into the counter.
`include "tshr_params.svh"
module tshr_readout
    import tshr_pkg::*;
#(
    parameter logic [8:0] COUNT_BASE = `TSHR_COUNT_BASE,
    parameter logic [8:0] SLOPE_BASE = `TSHR_SLOPE_BASE,
    parameter logic [8:0] SLOPE_STEP = `TSHR_SLOPE_STEP,
    parameter logic [15:0] GATE_TICKS = `TSHR_GATE_TICKS
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic osc_low,
    input wire logic osc_high,
    input wire logic sclk,
    input wire logic sel,
    input wire logic dq_in,
    output logic dq_out,
    output logic dq_oe_n,
    output logic conv_busy,
    output logic conv_done,
    output logic single_conversion_mode
);
    ////////////////////////////////////////////////////////////////////////////////
    // oscillator sampling

    logic lo_s1_ff, lo_s2_ff, lo_d_ff;
    logic hi_s1_ff, hi_s2_ff, hi_d_ff;
    // both oscillators must run well below mclk/2 or edges are lost
    wire low_tick = lo_s2_ff & ~lo_d_ff;
    wire high_tick = hi_s2_ff & ~hi_d_ff;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            lo_s1_ff <= 1'b0;
            lo_s2_ff <= 1'b0;
            lo_d_ff <= 1'b0;
            hi_s1_ff <= 1'b0;
            hi_s2_ff <= 1'b0;
            hi_d_ff <= 1'b0;
        end else begin
            lo_s1_ff <= osc_low;
            lo_s2_ff <= lo_s1_ff;
            lo_d_ff <= lo_s2_ff;
            hi_s1_ff <= osc_high;
            hi_s2_ff <= hi_s1_ff;
            hi_d_ff <= hi_s2_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // command events from the link

    tshr_cmd_t lnk_cmd;
    logic lnk_cmd_tgl;
    logic cmd_s1_ff, cmd_s2_ff, cmd_d_ff;
    // the command word is held by the link far longer than this crossing takes
    wire cmd_ev = cmd_s2_ff ^ cmd_d_ff;
    wire ev_wr_cfg = cmd_ev && (lnk_cmd.op == `TSHR_CMD_WR_CFG);
    wire ev_start = cmd_ev && (lnk_cmd.op == `TSHR_CMD_START);
    wire ev_ld_slope = cmd_ev && (lnk_cmd.op == `TSHR_CMD_LD_SLOPE);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cmd_s1_ff <= 1'b0;
            cmd_s2_ff <= 1'b0;
            cmd_d_ff <= 1'b0;
        end else begin
            cmd_s1_ff <= lnk_cmd_tgl;
            cmd_s2_ff <= cmd_s1_ff;
            cmd_d_ff <= cmd_s2_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // conversion control

    tshr_state_t state_ff, nxt_state;
    logic [7:0] cfg_ff;
    logic [8:0] meas_cnt, meas_temp;
    logic meas_gate, meas_done;
    wire single = cfg_ff[`TSHR_CFG_SINGLE];
    // without single conversion mode a finished conversion restarts at once
    wire rerun = (state_ff == tshr_st_conv) && meas_done && !single;
    wire start = ev_start | rerun;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            tshr_st_idle: begin
                if (start) begin
                    nxt_state = tshr_st_conv;
                end
            end
            tshr_st_conv: begin
                if (meas_done && !start) begin
                    nxt_state = tshr_st_idle;
                end
            end
            default: begin
                nxt_state = tshr_st_idle;
            end
        endcase
    end

    // done is set by the end of conversion and wins over the clear by a start
    wire done_set = meas_done;
    wire done_clr = ev_start;
    wire nxt_done = done_set | (cfg_ff[`TSHR_CFG_DONE] & ~done_clr);
    wire [7:0] nxt_cfg_wr = ev_wr_cfg ? (lnk_cmd.data & `TSHR_CFG_WR_MASK) :
        (cfg_ff & `TSHR_CFG_WR_MASK);
    wire [7:0] nxt_cfg = {nxt_done, nxt_cfg_wr[6:0]};

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= tshr_st_idle;
            cfg_ff <= `TSHR_CFG_RST;
        end else begin
            state_ff <= nxt_state;
            cfg_ff <= nxt_cfg;
        end
    end

    tshr_meas #(
        .COUNT_BASE(COUNT_BASE),
        .SLOPE_BASE(SLOPE_BASE),
        .SLOPE_STEP(SLOPE_STEP),
        .TEMP_PRESET(`TSHR_TEMP_PRESET),
        .GATE_TICKS(GATE_TICKS)
    ) u_meas (
        .mclk(mclk),
        .nrst(nrst),
        .start(start),
        .low_tick(low_tick),
        .high_tick(high_tick),
        .load_slope(ev_ld_slope),
        .cnt(meas_cnt),
        .temp(meas_temp),
        .gate(meas_gate),
        .done(meas_done)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // snapshot handed to the link

    tshr_snap_t snap_ff;
    logic req_ff, ack_s1_ff, ack_s2_ff;
    logic lnk_ack_tgl;
    // refresh only when the previous word has been taken, so the link never sees it move
    wire snap_free = (ack_s2_ff == req_ff);
    wire tshr_snap_t nxt_snap = tshr_snap_t'{cfg: cfg_ff, temp: meas_temp, cnt: meas_cnt};

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            snap_ff <= '0;
            req_ff <= 1'b0;
            ack_s1_ff <= 1'b0;
            ack_s2_ff <= 1'b0;
        end else begin
            ack_s1_ff <= lnk_ack_tgl;
            ack_s2_ff <= ack_s1_ff;
            if (snap_free) begin
                snap_ff <= nxt_snap;
                req_ff <= ~req_ff;
            end
        end
    end

    tshr_link u_link (
        .sclk(sclk),
        .nrst(nrst),
        .sel(sel),
        .dq_in(dq_in),
        .dq_out(dq_out),
        .dq_oe_n(dq_oe_n),
        .snap_req_tgl(req_ff),
        .snap(snap_ff),
        .snap_ack_tgl(lnk_ack_tgl),
        .cmd(lnk_cmd),
        .cmd_tgl(lnk_cmd_tgl)
    );

    logic busy_ff;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            busy_ff <= 1'b0;
        end else begin
            busy_ff <= (nxt_state == tshr_st_conv);
        end
    end
    assign conv_busy = busy_ff;
    assign conv_done = cfg_ff[`TSHR_CFG_DONE];
    assign single_conversion_mode = cfg_ff[`TSHR_CFG_SINGLE];

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    a_start_clears_done: assert property (
        @(posedge mclk) disable iff (!nrst)
        (ev_start && !meas_done) |=> !cfg_ff[`TSHR_CFG_DONE] && meas_gate && conv_busy)
        else $error("start did not clear done and open the gate");
    a_done_sets_flag: assert property (
        @(posedge mclk) disable iff (!nrst)
        meas_done |=> cfg_ff[`TSHR_CFG_DONE])
        else $error("done flag not set at end of conversion");
    a_done_holds: assert property (
        @(posedge mclk) disable iff (!nrst)
        (cfg_ff[`TSHR_CFG_DONE] && !ev_start) |=> cfg_ff[`TSHR_CFG_DONE])
        else $error("done flag dropped without a start");
    a_cfg_write_mode: assert property (
        @(posedge mclk) disable iff (!nrst)
        ev_wr_cfg |=> single_conversion_mode == $past(lnk_cmd.data[`TSHR_CFG_SINGLE]))
        else $error("configuration write not applied");
    a_snap_stable: assert property (
        @(posedge mclk) disable iff (!nrst)
        !snap_free |=> $stable(snap_ff))
        else $error("snapshot changed while handed over");
    a_snap_temp: assert property (
        @(posedge mclk) disable iff (!nrst)
        snap_free |=> snap_ff.temp == $past(meas_temp) && snap_ff.cnt == $past(meas_cnt))
        else $error("snapshot does not carry temperature and count");
    a_ld_slope_path: assert property (
        @(posedge mclk) disable iff (!nrst)
        (ev_ld_slope && !start && !meas_gate) ##1 (!meas_gate [*2]) |-> $stable(meas_cnt))
        else $error("counter moved after slope load with gate closed");
    a_single_stops: assert property (
        @(posedge mclk) disable iff (!nrst)
        (meas_done && single && !ev_start) |=> !conv_busy ##1 !meas_gate)
        else $error("single conversion did not stop");
    a_gate_bounded: assert property (
        @(posedge mclk) disable iff (!nrst)
        $rose(meas_gate) |-> ##[1:600] (!meas_gate || high_tick))
        else $error("gate open with no high oscillator edge");
    // the link holds each command word for a whole frame, so a toggle gives one event
    a_cmd_event_single: assert property (
        @(posedge mclk) disable iff (!nrst)
        cmd_ev |=> !cmd_ev)
        else $error("one link command gave two events");
    a_low_tick_single: assert property (
        @(posedge mclk) disable iff (!nrst)
        low_tick |=> !low_tick)
        else $error("low oscillator edge counted twice");
    a_high_tick_single: assert property (
        @(posedge mclk) disable iff (!nrst)
        high_tick |=> !high_tick)
        else $error("high oscillator edge counted twice");
    a_idle_gate_shut: assert property (
        @(posedge mclk) disable iff (!nrst)
        (state_ff == tshr_st_idle) |-> !meas_gate)
        else $error("gate open while no conversion runs");
    a_idle_not_busy: assert property (
        @(posedge mclk) disable iff (!nrst)
        (state_ff == tshr_st_idle && !start) |=> !conv_busy)
        else $error("busy raised without a start");
    a_gate_fall_done: assert property (
        @(posedge mclk) disable iff (!nrst)
        $fell(meas_gate) |-> meas_done)
        else $error("gate closed without an end of conversion");
    a_done_one_cycle: assert property (
        @(posedge mclk) disable iff (!nrst)
        meas_done |=> !meas_done)
        else $error("end of conversion longer than one cycle");
    a_done_rise_cause: assert property (
        @(posedge mclk) disable iff (!nrst)
        $rose(conv_done) |-> $past(meas_done))
        else $error("done flag set with no conversion end");
    // without single conversion mode nothing waits for the host between runs
    a_rerun_restarts: assert property (
        @(posedge mclk) disable iff (!nrst)
        (meas_done && !single && state_ff == tshr_st_conv) |=> meas_gate && conv_busy)
        else $error("continuous mode did not restart the conversion");
    a_cfg_write_bits: assert property (
        @(posedge mclk) disable iff (!nrst)
        ev_wr_cfg |=> (cfg_ff & `TSHR_CFG_WR_MASK) == ($past(lnk_cmd.data) & `TSHR_CFG_WR_MASK))
        else $error("configuration write lost a mode bit");
    a_cfg_mode_holds: assert property (
        @(posedge mclk) disable iff (!nrst)
        !ev_wr_cfg |=> (cfg_ff & `TSHR_CFG_WR_MASK) == ($past(cfg_ff) & `TSHR_CFG_WR_MASK))
        else $error("mode bits changed without a write");
    a_cfg_unused_zero: assert property (
        @(posedge mclk) disable iff (!nrst)
        cfg_ff[`TSHR_CFG_DONE-1:`TSHR_CFG_HOST+1] == '0)
        else $error("unused configuration bits not zero");
    a_snap_req_toggle: assert property (
        @(posedge mclk) disable iff (!nrst)
        snap_free |=> req_ff != $past(req_ff))
        else $error("fresh snapshot not offered to the link");
endmodule

// ### verification/tshr_host.sv
// host controller model that frames commands on the serial port
module tshr_host (
    output logic sclk,
    output logic sel,
    output logic dq_in,
    input wire logic dq_out,
    input wire logic dq_oe_n,
    output logic rd_stb,
    output logic [8:0] rd_data,
    output logic drv_seen
);
    timeunit 1ns;
    timeprecision 100ps;
    logic last_ff;
    wire logic dq_wire;
    // an undriven line shows the inverse of its last driven level, never a stale copy
    assign dq_wire = dq_oe_n ? ~last_ff : dq_out;
    initial begin
        sclk = 1'b0;
        sel = 1'b0;
        dq_in = 1'b0;
        rd_stb = 1'b0;
        rd_data = 9'h000;
        drv_seen = 1'b0;
        last_ff = 1'b0;
    end
    always @(posedge sclk) begin
        if (!dq_oe_n) last_ff <= dq_out;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // two link edges while reset is held, with select low
    task rst_clk();
        #4 sclk = 1'b1;
        #32 sclk = 1'b0;
    endtask
    // one framed transaction: command, nw write bits, nr read bits, all lsb first
    task xfer(input logic [7:0] op, input logic [7:0] wd, input int nw, input int nr);
        int i;
        logic [8:0] rd;
        rd = 9'h000;
        drv_seen = 1'b0;
        // odd offset keeps the link edges away from the system clock edges
        #1.3 sel = 1'b1;
        for (i = 0; i < 8 + nw + nr; i++) begin
            dq_in = (i < 8) ? op[i] : (i < 8 + nw) ? wd[i - 8] : 1'b0;
            #32;
            if (i >= 8 + nw) begin
                rd[i - 8 - nw] = dq_wire;
                if (!dq_oe_n) drv_seen = 1'b1;
            end
            sclk = 1'b1;
            #32 sclk = 1'b0;
        end
        #32 sel = 1'b0;
        dq_in = ~dq_in;
        if (drv_seen) begin
            rd_data = rd;
            rd_stb = 1'b1;
            #4 rd_stb = 1'b0;
        end
        #100;
    endtask
endmodule

// ### verification/tshr_readout_tb.sv
// self-checking bench for the temperature readout top
`include "tshr_params.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tshr_readout_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [8:0] CB = 9'h005;
    localparam logic [8:0] SB = 9'h003;
    localparam logic [8:0] SS = 9'h001;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic osc_low = 1'b0;
    logic osc_high = 1'b0;
    wire logic sclk, sel, dq_in, dq_out, dq_oe_n, conv_busy, conv_done, scm, rd_stb, drv_seen;
    wire logic [8:0] rd_data;
    int miscompares = 0;
    int total_checks = 0;
    int seed = 96628;
    logic [8:0] exp_q[$];
    logic [8:0] exp_v;
    tshr_readout #(.COUNT_BASE(CB), .SLOPE_BASE(SB), .SLOPE_STEP(SS),
        .GATE_TICKS(16'h0008)) tshr_readout_i (.mclk(mclk), .nrst(nrst), .osc_low(osc_low),
        .osc_high(osc_high), .sclk(sclk), .sel(sel), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe_n(dq_oe_n), .conv_busy(conv_busy), .conv_done(conv_done),
        .single_conversion_mode(scm));
    tshr_host tshr_host_i (.sclk(sclk), .sel(sel), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe_n(dq_oe_n), .rd_stb(rd_stb), .rd_data(rd_data), .drv_seen(drv_seen));
    always #2 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////////////
    // read results are judged in arrival order against the notes of the driver
    always @(posedge rd_stb) begin
        if (exp_q.size() == 0) begin
            miscompares++;
            $display("[ERR] read_data exp none got %h", rd_data);
        end else begin
            exp_v = exp_q.pop_front();
            `CHK("read_data", exp_v, rd_data)
        end
    end
    task test_done();
        if (miscompares == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #300000;
        miscompares++;
        test_done();
    end
    ////////////////////////////////////////////////////////////////////////////////
    task settle();
        repeat (30) @(posedge mclk);
        #1;
    endtask
    // oscillator edges well below mclk/4 so the synchroniser sees every one
    task pulse(input bit hi, input int n);
        int k;
        for (k = 0; k < n; k++) begin
            @(posedge mclk);
            #1;
            if (hi) osc_high = 1'b1;
            else osc_low = 1'b1;
            repeat (5) @(posedge mclk);
            #1;
            osc_high = 1'b0;
            osc_low = 1'b0;
            repeat (4) @(posedge mclk);
            #1;
        end
    endtask
    task run(input logic [7:0] mode);
        int n, k;
        logic [8:0] c, t, s;
        real fine;
        tshr_host_i.xfer(`TSHR_CMD_WR_CFG, mode, 8, 0);
        settle();
        `CHK("single_mode", mode[0], scm)
        tshr_host_i.xfer(`TSHR_CMD_START, 8'h00, 0, 0);
        settle();
        `CHK("busy", 1'b1, conv_busy)
        `CHK("done_clear", 1'b0, conv_done)
        n = ($random(seed) & 31) + 2;
        c = CB;
        t = `TSHR_TEMP_PRESET;
        s = SB;
        for (k = 0; k < n; k++) begin
            if (c == 9'h000) begin
                t = t + 9'h001;
                c = s;
                s = s + SS;
            end else c = c - 9'h001;
        end
        pulse(1'b0, n);
        settle();
        pulse(1'b1, 8);
        k = 0;
        while (conv_done !== 1'b1 && k < 200) begin
            @(posedge mclk);
            #1;
            k++;
        end
        `CHK("done_set", 1'b1, conv_done)
        `CHK("busy_end", 1'b0, conv_busy)
        // ticks after the gate closed must leave the residue alone
        pulse(1'b0, 3);
        exp_q.push_back({1'b0, 8'h80 | mode});
        tshr_host_i.xfer(`TSHR_CMD_RD_CFG, 8'h00, 0, 8);
        `CHK("drive_cfg", 1'b1, drv_seen)
        exp_q.push_back(t);
        tshr_host_i.xfer(`TSHR_CMD_RD_TEMP, 8'h00, 0, 9);
        exp_q.push_back(c);
        tshr_host_i.xfer(`TSHR_CMD_RD_CNT, 8'h00, 0, 9);
        tshr_host_i.xfer(`TSHR_CMD_LD_SLOPE, 8'h00, 0, 0);
        exp_q.push_back(s);
        tshr_host_i.xfer(`TSHR_CMD_RD_CNT, 8'h00, 0, 9);
        fine = $itor($signed(t[8:1])) - 0.25 + $itor(int'(s) - int'(c)) / $itor(s);
    endtask
    initial begin
        fork
            tshr_host_i.rst_clk();
        join_none
        repeat (12) @(posedge mclk);
        #1 nrst = 1'b1;
        settle();
        `CHK("busy_rst", 1'b0, conv_busy)
        `CHK("done_rst", 1'b0, conv_done)
        `CHK("mode_rst", 1'b0, scm)
        `CHK("oe_rst", 1'b1, dq_oe_n)
        tshr_host_i.xfer(8'h55, 8'h00, 0, 9);
        `CHK("drive_unknown", 1'b0, drv_seen)
        run(8'h03);
        run(8'h01);
        // continuous mode: the end of one conversion opens the next at once
        tshr_host_i.xfer(`TSHR_CMD_WR_CFG, 8'h00, 8, 0);
        tshr_host_i.xfer(`TSHR_CMD_START, 8'h00, 0, 0);
        pulse(1'b1, 8);
        `CHK("rerun_busy", 1'b1, conv_busy)
        `CHK("rerun_done", 1'b1, conv_done)
        exp_q.push_back(`TSHR_TEMP_PRESET);
        tshr_host_i.xfer(`TSHR_CMD_RD_TEMP, 8'h00, 0, 9);
        settle();
        `CHK("queue_left", 0, exp_q.size())
        test_done();
    end
endmodule
